// *** include/mpa_regs.svh ***
`ifndef MPA_REGS_SVH
`define MPA_REGS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define MPA_CYC_PER_MS    200000
`define MPA_UPD_MS0       50
`define MPA_UPD_MS1       100
`define MPA_UPD_MS2       200
`define MPA_UPD_MS3       500
`define MPA_UPD_MS4       1000
`define MPA_UPD_MS5       2000
`define MPA_UPD_MS6       5000
`define MPA_MS_PER_S      1000
`define MPA_PLL_LO_HZ     55
`define MPA_PLL_HI_HZ     75

// ----------------------------------------
// Scaling and formatting
// ----------------------------------------
`define MPA_FRAC          8
`define MPA_RATIO_RST     16'h0100
`define MPA_HYST3_Q8      13
`define MPA_HYST6_Q8      26
`define MPA_FULL_COUNT    60000
`define MPA_DEC_BASE      10

// ----------------------------------------
// Averaging
// ----------------------------------------
`define MPA_MOV_BASE      8
`define MPA_REC_FRAC      16
`define MPA_REC_K5625     11651
`define MPA_REC_K46875    13981
`define MPA_DIV_STEPS     40

`endif

// *** include/mpa_pkg.sv ***
package mpa_pkg;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_AVG  = 3'h1,
      ST_MRD  = 3'h3,
      ST_DIV  = 3'h2,
      ST_FMT  = 3'h6,
      ST_PUSH = 3'h7
   } mpa_state_t;

   typedef enum logic [2:0]
   {
      K_VOLT  = 3'h0,
      K_CURR  = 3'h1,
      K_POWER = 3'h2,
      K_CPEAK = 3'h3,
      K_OTHER = 3'h4
   } mpa_kind_t;

   typedef enum logic [1:0]
   {
      AV_OFF = 2'h0,
      AV_EXP = 2'h1,
      AV_MOV = 2'h2
   } mpa_avg_t;

endpackage

// *** rtl/mpa_hist_ram.sv ***
module mpa_hist_ram
   import mpa_pkg::*;
#(
   parameter int W     = 32,
   parameter int DEPTH = 256,
   parameter int AW    = 8
)
(
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          ce,
   input  wire logic          we,
   input  wire logic [AW-1:0] wAddr,
   input  wire logic [W-1:0]  wData,
   input  wire logic [AW-1:0] rAddr,
   output logic      [W-1:0]  rData
);

   // ----------------------------------------
   // Storage, read before write
   // ----------------------------------------
   logic [W-1:0] mem [DEPTH];
   logic [W-1:0] rData_ff;

   always_ff @(posedge clk)
   begin
      if (ce && we)
      begin
         mem[wAddr] <= wData;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rData_ff <= '0;
      end
      else if (ce)
      begin
         rData_ff <= mem[rAddr];
      end
   end

   assign rData = rData_ff;

endmodule

// *** rtl/mpa_averager.sv ***
// Functional notes
// (R01) Sensor input divides current and power by ratio
// (R02) Transformer scales voltage and current by ratios
// (R03) Transformer power uses both ratios and coefficient
// (R04) Zero crossing hysteresis 5% or 10% range
// (R05) Zero crossings give period, frequency, lock period
// (R06) Exponential average, first output equals measurement
// (R07) Moving average over last m measurements
// (R08) Harmonic mode uses automatic exponential constant
// (R09) Constant 5.625 in 55-75 Hz, else 4.6875
// (R10) Publish once per selected update period
// (R11) Harmonic update period from lock source periods
// (R12) Hold freezes published and communicated results
// (R13) Single request while held publishes once
// (R14) Maximum hold keeps largest value seen
// (R15) Master drives start/stop, slave follows them
// (R16) Display count full scale 60000
// (R17) Sum takes coarsest element decimal position
// (R18) Moving average warms up over collected measurements
`include "mpa_regs.svh"
module mpa_averager
   import mpa_pkg::*;
#(
   parameter int DW         = 32,
   parameter int NELEM      = 6,
   parameter int CYC_PER_MS = `MPA_CYC_PER_MS
)
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic              mValid,
   input  wire logic [DW-1:0]     mData,
   input  wire logic [2:0]        mKind,
   output logic                   mReady,
   input  wire logic              zcValid,
   input  wire logic [DW-1:0]     zcSample,
   input  wire logic [DW-1:0]     measRange,
   input  wire logic              crest6,
   input  wire logic              sensorSel,
   input  wire logic [15:0]       sensorRatio,
   input  wire logic              xfmrSel,
   input  wire logic [15:0]       vtRatio,
   input  wire logic [15:0]       ctRatio,
   input  wire logic [15:0]       powerCoef,
   input  wire logic [1:0]        avgMode,
   input  wire logic [2:0]        expSel,
   input  wire logic [2:0]        movSel,
   input  wire logic              harmonic,
   input  wire logic [7:0]        periodsPerAnalysis,
   input  wire logic [2:0]        updSel,
   input  wire logic              hold,
   input  wire logic              singleReq,
   input  wire logic              maxHold,
   input  wire logic              syncEn,
   input  wire logic              syncMaster,
   input  wire logic              syncStartIn,
   input  wire logic              syncStopIn,
   output logic                   syncStartOut,
   output logic                   syncStopOut,
   input  wire logic              rangeRating,
   input  wire logic [NELEM*4-1:0] elemScale,
   output logic [3:0]             sumScale,
   output logic                   outValid,
   input  wire logic              outReady,
   output logic [DW-1:0]          outValue,
   output logic [17:0]            outCount,
   output logic [3:0]             outScale,
   output logic [DW-1:0]          outMax,
   output logic                   zcBoundary,
   output logic [31:0]            zcPeriod,
   output logic                   pllInBand
);

   // ----------------------------------------
   // Types and constants
   // ----------------------------------------
   localparam int QW = DW + 8;
   localparam int BW = 2 * DW + 22;
   localparam logic [31:0] CYC_55 = 32'(CYC_PER_MS * `MPA_MS_PER_S / `MPA_PLL_LO_HZ);
   localparam logic [31:0] CYC_75 = 32'(CYC_PER_MS * `MPA_MS_PER_S / `MPA_PLL_HI_HZ);
   localparam logic signed [DW+16:0] MAXV = {18'h0, {(DW-1){1'b1}}};
   localparam logic signed [DW+16:0] MINV = ~MAXV;
   localparam logic signed [DW-1:0] FULL = DW'(`MPA_FULL_COUNT);

   typedef struct packed {
      mpa_state_t            state;
      logic                  rdy;
      logic signed [DW-1:0]  cur;
      logic [2:0]            kind;
      logic [QW-1:0]         divNum;
      logic [QW-1:0]         divDen;
      logic [QW:0]           divRem;
      logic [5:0]            divCnt;
      logic                  divNeg;
      logic                  divMean;
      logic signed [DW-1:0]  avgD;
      logic                  first;
      logic signed [QW-1:0]  sum;
      logic [8:0]            cnt;
      logic [7:0]            wPtr;
      logic [9:0]            cfg;
      logic [31:0]           tmr;
      logic                  pubPend;
      logic                  singleArm;
      logic signed [DW-1:0]  pubVal;
      logic signed [DW-1:0]  fmt;
      logic [3:0]            dp;
      logic signed [DW-1:0]  maxV;
      logic                  maxValid;
      logic                  zcPol;
      logic [31:0]           zcCnt;
      logic [31:0]           zcPer;
      logic                  zcBound;
      logic                  inBand;
      logic                  syStartM;
      logic                  syStartS;
      logic                  syStartD;
      logic                  syStopM;
      logic                  syStopS;
      logic                  syStopD;
      logic                  winOpen;
      logic                  syStartOut;
      logic                  syStopOut;
      logic [3:0]            sumDp;
      logic [BW-1:0]         b0;
      logic [BW-1:0]         b1;
      logic [1:0]            bCnt;
      logic                  outV;
   } mpa_st_t;

   mpa_st_t st_ff;
   mpa_st_t nxt_st;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic signed [DW-1:0] mulq(input logic signed [DW-1:0] a,
                                                 input logic [15:0] r);
      logic signed [DW+16:0] p;
      p = (a * $signed({1'b0, r})) >>> `MPA_FRAC;
      mulq = (p > MAXV) ? MAXV[DW-1:0] : (p < MINV) ? MINV[DW-1:0] : p[DW-1:0];
   endfunction
   localparam int UPD_MS [8] = '{`MPA_UPD_MS0, `MPA_UPD_MS1, `MPA_UPD_MS2, `MPA_UPD_MS3,
                                 `MPA_UPD_MS4, `MPA_UPD_MS5, `MPA_UPD_MS6, `MPA_UPD_MS6};

   // ----------------------------------------
   // History memory and sum scale chain
   // ----------------------------------------
   logic          memWe;
   logic [7:0]    memRAddr;
   logic [DW-1:0] memRData;
   logic [3:0]    dpChain [NELEM+1];

   mpa_hist_ram #(.W(DW), .DEPTH(256), .AW(8)) uHist
   (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .we    (memWe),
      .wAddr (st_ff.wPtr),
      .wData (st_ff.cur),
      .rAddr (memRAddr),
      .rData (memRData)
   );

   assign dpChain[0] = 4'h0;
   for (genvar g = 0; g < NELEM; g++)
   begin : gScale
      assign dpChain[g+1] = (elemScale[g*4 +: 4] > dpChain[g]) ? elemScale[g*4 +: 4]
                                                               : dpChain[g]; // R17
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   logic [8:0]              mLen;
   logic signed [DW-1:0]    xf;
   logic signed [DW:0]      diff;
   logic signed [DW+17:0]   hprod;
   logic [DW+4:0]           hystW;
   logic signed [DW-1:0]    hyst;
   logic [31:0]             period;
   logic [39:0]             harmCyc;
   logic                    slave;
   logic                    tick;
   logic                    startEdge;
   logic                    stopEdge;
   logic [QW:0]             trial;
   logic [QW-1:0]           qNew;
   logic signed [QW-1:0]    newSum;
   logic signed [DW-1:0]    oldVal;
   logic signed [DW-1:0]    maxNew;
   logic                    pop;
   logic                    push;
   logic [1:0]              c;
   logic [BW-1:0]           word;
   logic                    isI;

   always_comb
   begin
      nxt_st  = st_ff;
      memWe   = 1'b0;
      push    = 1'b0;
      mLen    = 9'(`MPA_MOV_BASE) << movSel;
      memRAddr = st_ff.wPtr - mLen[7:0];
      isI     = (mKind == K_CURR) || (mKind == K_POWER) || (mKind == K_CPEAK);
      // Sync pin stages
      nxt_st.syStartM = syncStartIn;
      nxt_st.syStartS = st_ff.syStartM;
      nxt_st.syStartD = st_ff.syStartS;
      nxt_st.syStopM  = syncStopIn;
      nxt_st.syStopS  = st_ff.syStopM;
      nxt_st.syStopD  = st_ff.syStopS;
      startEdge = st_ff.syStartS & ~st_ff.syStartD;
      stopEdge  = st_ff.syStopS & ~st_ff.syStopD;
      slave     = syncEn & ~syncMaster;
      // Zero crossing detector
      hystW = (DW+5)'(measRange) * (DW+5)'(crest6 ? `MPA_HYST6_Q8 : `MPA_HYST3_Q8);
      hyst  = $signed(DW'(hystW >> `MPA_FRAC)); // R04
      nxt_st.zcCnt   = st_ff.zcCnt + 32'h1;
      nxt_st.zcBound = 1'b0;
      if (zcValid)
      begin
         if (!st_ff.zcPol && ($signed(zcSample) > hyst))
         begin
            nxt_st.zcPol   = 1'b1;
            nxt_st.zcPer   = st_ff.zcCnt + 32'h1; // R05
            nxt_st.zcCnt   = 32'h0;
            nxt_st.zcBound = 1'b1; // R05
         end
         else if (st_ff.zcPol && ($signed(zcSample) < -hyst))
         begin
            nxt_st.zcPol = 1'b0; // R04
         end
      end
      nxt_st.inBand = (st_ff.zcPer >= CYC_75) && (st_ff.zcPer <= CYC_55); // R09
      // Update period timer
      harmCyc = 40'(st_ff.zcPer) * 40'(periodsPerAnalysis);
      period  = harmonic ? harmCyc[31:0] : 32'(UPD_MS[updSel]) * 32'(CYC_PER_MS); // R10 R11
      tick    = slave ? stopEdge : (st_ff.tmr + 32'h1 >= period); // R10 R15
      nxt_st.tmr = tick ? 32'h0 : st_ff.tmr + 32'h1;
      if (tick)
      begin
         if (!hold || st_ff.singleArm)
            nxt_st.pubPend = 1'b1; // R12 R13
         nxt_st.singleArm = 1'b0; // R13
      end
      if (singleReq && hold)
      begin
         nxt_st.singleArm = 1'b1; // R13
         nxt_st.tmr       = 32'h0;
      end
      nxt_st.syStopOut  = syncEn & syncMaster & tick; // R15
      nxt_st.syStartOut = st_ff.syStopOut; // R15
      if (startEdge)
         nxt_st.winOpen = 1'b1; // R15
      else if (stopEdge)
         nxt_st.winOpen = 1'b0; // R15
      // Transformer scaling
      xf = $signed(mData);
      if (xfmrSel)
      begin
         case (mKind)
            K_VOLT:  xf = mulq($signed(mData), vtRatio); // R02
            K_CURR,
            K_CPEAK: xf = mulq($signed(mData), ctRatio); // R02
            K_POWER: xf = mulq(mulq(mulq($signed(mData), vtRatio), ctRatio), powerCoef); // R03
            default: xf = $signed(mData);
         endcase
      end
      // Shared divider step
      trial = {st_ff.divRem[QW-1:0], st_ff.divNum[QW-1]};
      qNew  = {st_ff.divNum[QW-2:0], 1'b0};
      diff  = (DW+1)'(st_ff.cur) - (DW+1)'(st_ff.avgD);
      hprod = diff * $signed({1'b0, st_ff.inBand ? 17'(`MPA_REC_K5625)
                                                 : 17'(`MPA_REC_K46875)}); // R09
      oldVal = (st_ff.cnt == mLen) ? $signed(memRData) : '0; // R07
      newSum = st_ff.sum + QW'(st_ff.cur) - QW'(oldVal); // R07
      maxNew = (maxHold && st_ff.maxValid && (st_ff.maxV > st_ff.pubVal)) ? st_ff.maxV
                                                                         : st_ff.pubVal; // R14
      word = {maxNew, st_ff.pubVal, st_ff.fmt[17:0], st_ff.dp};
      case (st_ff.state)
         ST_IDLE:
         begin
            if (mValid && st_ff.rdy)
            begin
               nxt_st.cur  = xf;
               nxt_st.kind = mKind;
               nxt_st.state = ST_AVG;
               if (sensorSel && isI)
               begin
                  nxt_st.divNum  = QW'(xf[DW-1] ? -xf : xf); // R01
                  nxt_st.divDen  = QW'((sensorRatio == 16'h0) ? 16'h1 : sensorRatio); // R01
                  nxt_st.divRem  = '0;
                  nxt_st.divCnt  = 6'(`MPA_DIV_STEPS);
                  nxt_st.divNeg  = xf[DW-1];
                  nxt_st.divMean = 1'b0;
                  nxt_st.state   = ST_DIV;
               end
            end
            else if (st_ff.pubPend)
            begin
               nxt_st.pubPend = 1'b0;
               nxt_st.pubVal  = st_ff.avgD; // R12
               nxt_st.fmt     = st_ff.avgD;
               nxt_st.dp      = 4'h0;
               nxt_st.state   = ST_FMT;
            end
         end
         ST_AVG:
         begin
            nxt_st.state = ST_IDLE;
            if (!harmonic && (avgMode == AV_MOV))
            begin
               memWe        = 1'b1; // R07
               nxt_st.state = ST_MRD;
            end
            else if (st_ff.first || (!harmonic && (avgMode == AV_OFF)))
            begin
               nxt_st.avgD  = st_ff.cur; // R06
               nxt_st.first = 1'b0;
            end
            else if (harmonic)
               nxt_st.avgD = st_ff.avgD + DW'(hprod >>> `MPA_REC_FRAC); // R08
            else
               nxt_st.avgD = st_ff.avgD + DW'(diff >>> (expSel + 3'h1)); // R06
         end
         ST_MRD:
         begin
            nxt_st.sum     = newSum;
            nxt_st.cnt     = (st_ff.cnt == mLen) ? st_ff.cnt : st_ff.cnt + 9'h1; // R18
            nxt_st.wPtr    = st_ff.wPtr + 8'h1;
            nxt_st.divNum  = newSum[QW-1] ? -newSum : newSum;
            nxt_st.divDen  = QW'(nxt_st.cnt); // R18
            nxt_st.divRem  = '0;
            nxt_st.divCnt  = 6'(`MPA_DIV_STEPS);
            nxt_st.divNeg  = newSum[QW-1];
            nxt_st.divMean = 1'b1;
            nxt_st.state   = ST_DIV;
         end
         ST_DIV:
         begin
            if (trial >= {1'b0, st_ff.divDen})
            begin
               nxt_st.divRem = trial - {1'b0, st_ff.divDen};
               qNew[0]       = 1'b1;
            end
            else
               nxt_st.divRem = trial;
            nxt_st.divNum = qNew;
            nxt_st.divCnt = st_ff.divCnt - 6'h1;
            if (st_ff.divCnt == 6'h1)
            begin
               if (st_ff.divMean)
               begin
                  nxt_st.avgD  = st_ff.divNeg ? -$signed(qNew[DW-1:0])
                                              : $signed(qNew[DW-1:0]); // R07
                  nxt_st.state = ST_IDLE;
               end
               else
               begin
                  nxt_st.cur   = st_ff.divNeg ? -$signed(qNew[DW-1:0])
                                              : $signed(qNew[DW-1:0]); // R01
                  nxt_st.state = ST_AVG;
               end
            end
         end
         ST_FMT:
         begin
            if ((st_ff.fmt > FULL) || (st_ff.fmt < -FULL))
            begin
               nxt_st.fmt = st_ff.fmt / DW'(`MPA_DEC_BASE); // R16
               nxt_st.dp  = st_ff.dp + 4'h1; // R16
            end
            else
               nxt_st.state = ST_PUSH;
         end
         ST_PUSH:
         begin
            if ((st_ff.bCnt != 2'h2) || (st_ff.outV && outReady))
            begin
               push            = 1'b1;
               nxt_st.maxV     = maxNew; // R14
               nxt_st.maxValid = maxHold; // R14
               nxt_st.state    = ST_IDLE;
            end
         end
         default:
            nxt_st.state = ST_IDLE;
      endcase
      // Settings change restarts averaging
      if ({avgMode, expSel, movSel, harmonic, 1'b0} != st_ff.cfg)
      begin
         nxt_st.cfg   = {avgMode, expSel, movSel, harmonic, 1'b0};
         nxt_st.cnt   = 9'h0; // R18
         nxt_st.sum   = '0;
         nxt_st.first = 1'b1; // R06
      end
      // Two-entry output buffer
      pop = st_ff.outV && outReady;
      c   = st_ff.bCnt;
      if (pop)
      begin
         nxt_st.b0 = st_ff.b1;
         c = c - 2'h1;
      end
      if (push)
      begin
         if (c == 2'h0)
            nxt_st.b0 = word;
         else
            nxt_st.b1 = word;
         c = c + 2'h1;
      end
      nxt_st.bCnt  = c;
      nxt_st.outV  = (c != 2'h0);
      nxt_st.sumDp = rangeRating ? dpChain[NELEM] : 4'h0; // R17
      nxt_st.rdy   = (st_ff.state == ST_IDLE) && (nxt_st.state == ST_IDLE) && !nxt_st.pubPend
                     && (!slave || nxt_st.winOpen); // R15
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_ff       <= '0;
         st_ff.state <= ST_IDLE;
         st_ff.first <= 1'b1;
      end
      else if (ce)
      begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign mReady       = st_ff.rdy;
   assign syncStartOut = st_ff.syStartOut;
   assign syncStopOut  = st_ff.syStopOut;
   assign sumScale     = st_ff.sumDp;
   assign outValid     = st_ff.outV;
   assign outMax       = st_ff.b0[BW-1 -: DW];
   assign outValue     = st_ff.b0[DW+21 -: DW];
   assign outCount     = st_ff.b0[21:4];
   assign outScale     = st_ff.b0[3:0];
   assign zcBoundary   = st_ff.zcBound;
   assign zcPeriod     = st_ff.zcPer;
   assign pllInBand    = st_ff.inBand;

endmodule

// *** sim/mpa_averager_properties.sv ***
// ----------------------------------------
// Output checks
// ----------------------------------------
module mpa_averager_properties
   import mpa_pkg::*;
#(
   parameter int NELEM = 6
)
(
   input wire logic               clk,
   input wire logic               rst,
   input wire logic               mValid,
   input wire logic               mReady,
   input wire logic               maxHold,
   input wire logic               syncStartOut,
   input wire logic               syncStopOut,
   input wire logic               rangeRating,
   input wire logic [NELEM*4-1:0] elemScale,
   input wire logic [3:0]         sumScale,
   input wire logic               outValid,
   input wire logic               outReady,
   input wire logic [31:0]        outValue,
   input wire logic [17:0]        outCount,
   input wire logic [31:0]        outMax,
   input wire logic               zcBoundary
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   function automatic logic [3:0] maxScale(input logic [NELEM*4-1:0] s);
      maxScale = 4'h0;
      for (int g = 0; g < NELEM; g++)
         if (s[4*g +: 4] > maxScale) maxScale = s[4*g +: 4];
   endfunction

   AST_SYNC_SEQ: assert property (syncStopOut |=> syncStartOut && !syncStopOut)
      else $error("start pulse did not follow stop pulse");
   AST_SYNC_PULSE: assert property (syncStartOut |=> !syncStartOut ##1 !syncStopOut)
      else $error("start pulse longer than one cycle");
   AST_OUT_STALL: assert property (outValid && !outReady |=> outValid && $stable(outValue))
      else $error("published word changed while stalled");
   AST_COUNT_FS: assert property (outValid |-> $signed(outCount) <= 60000 && $signed(outCount) >= -60000)
      else $error("display count beyond full scale");
   AST_MAX_GE: assert property (outValid && maxHold |-> $signed(outMax) >= $signed(outValue))
      else $error("held maximum below value");
   AST_MAX_EQ: assert property (outValid && !maxHold |-> outMax == outValue)
      else $error("maximum differs from value with hold off");
   AST_SUM_SCALE: assert property (sumScale == ($past(rangeRating) ? maxScale($past(elemScale)) : 4'h0))
      else $error("sum scale wrong");
   AST_MREADY_GAP: assert property (mValid && mReady |=> !mReady [*2])
      else $error("measurement taken too soon after previous");
   AST_ZC_PULSE: assert property (zcBoundary |=> !zcBoundary)
      else $error("boundary pulse longer than one cycle");

   cover property (outValid && outReady);
   cover property (syncStopOut);
   cover property (mValid && mReady && maxHold);
   cover property (zcBoundary);
endmodule

bind mpa_averager mpa_averager_properties #(.NELEM(NELEM)) i_chk (.*);

// *** sim/mpa_front_model.sv ***
// ----------------------------------------
// Measurement source and result consumer
// ----------------------------------------
module mpa_front_model
(
   input  wire logic        clk,
   input  wire logic        mReady,
   output logic             mValid,
   output logic [31:0]      mData,
   output logic [2:0]       mKind,
   output logic             outReady
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
      {mValid, mData, mKind, outReady} = '0;

   // Consumer stalls at random
   always @(posedge clk)
      outReady <= ($urandom % 4) != 0;

   // Offer one value, hold until taken
   task automatic send(input logic [31:0] d, input logic [2:0] k);
      @(posedge clk);
      mValid <= 1'b1;
      mData  <= d;
      mKind  <= k;
      do
         @(posedge clk);
      while (mReady !== 1'b1);
      mValid <= 1'b0;
      mData  <= ~d;
      mKind  <= ~k;
   endtask
endmodule

// *** sim/tb.sv ***
// ----------------------------------------
// Testbench
// ----------------------------------------
module tb;
   import mpa_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [31:0] v; logic [17:0] c; logic [3:0] s; logic [31:0] x;} mpa_exp_t;
   logic        clk, rst, ce, mValid, mReady, zcValid, crest6, sensorSel, xfmrSel, harmonic;
   logic        hold, singleReq, maxHold, syncEn, syncMaster, syncStartIn, syncStopIn;
   logic        syncStartOut, syncStopOut, rangeRating, outValid, outReady, zcBoundary, pllInBand;
   logic [31:0] mData, zcSample, measRange, outValue, outMax, zcPeriod, d, v, r;
   logic [15:0] sensorRatio, vtRatio, ctRatio, powerCoef;
   logic [23:0] elemScale;
   logic [17:0] outCount;
   logic [7:0]  periodsPerAnalysis;
   logic [3:0]  sumScale, outScale, m;
   logic [2:0]  mKind, expSel, movSel, updSel;
   logic [1:0]  avgMode;
   mpa_exp_t    expQ[$];
   mpa_exp_t    e;
   int          numErrors, samplesChecked, zcCount;
   int          win[$];
   int          xf[4] = '{2, 3, 9, 3};
   int          dv[4] = '{1, 4, 4, 4};
   int          amp[3] = '{20, 45, 200};

   mpa_averager #(.CYC_PER_MS(20)) i_dut (.*);
   mpa_front_model i_front (.*);

   always #2.5 clk = ~clk;

   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      samplesChecked++;
      if (seen !== want)
      begin
         numErrors++;
         $display("wrong value at %0t: saw %0h, expected %0h", $time, seen, want);
      end
   endtask

   task automatic finalReport;
      $display("checks %0d, mismatches %0d", samplesChecked, numErrors);
      if (numErrors == 0 && samplesChecked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Single-shot publish while held
   task automatic pub(input logic [31:0] dd, input logic [2:0] k, input logic [31:0] vv,
                      input logic [31:0] xx);
      mpa_exp_t w;
      logic [31:0] c = vv;
      int n = 0;
      w = '{vv, 18'h0, 4'h0, xx};
      while (c > 60000)
      begin
         c = c / 10;
         w.s++;
      end
      w.c = c[17:0];
      expQ.push_back(w);
      i_front.send(dd, k);
      singleReq <= 1'b1;
      @(posedge clk);
      singleReq <= 1'b0;
      while (expQ.size() != 0 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      check(n >= 1000 && n < 1100, 1'b1);
   endtask

   // Result monitor
   always @(posedge clk)
      if (rst === 1'b0 && outValid === 1'b1 && outReady === 1'b1)
      begin
         if (expQ.size() == 0)
            check(1'b1, 1'b0);
         else
         begin
            e = expQ.pop_front();
            check(outValue, e.v);
            check(outCount, e.c);
            check(outScale, e.s);
            check(outMax, e.x);
         end
      end

   always @(posedge clk)
   begin
      syncStartIn <= 1'($urandom);
      syncStopIn <= 1'($urandom);
      if (zcBoundary === 1'b1) zcCount++;
   end

   initial
   begin
      #300us;
      numErrors++;
      finalReport;
   end

   initial
   begin
      {clk, rst, ce, hold, syncEn, syncMaster} = 6'h1f;
      {zcValid, crest6, sensorSel, xfmrSel, harmonic, singleReq, maxHold} = '0;
      {rangeRating, zcSample, measRange, sensorRatio, vtRatio, ctRatio} = '0;
      {powerCoef, elemScale, expSel, movSel, updSel, avgMode} = '0;
      void'($urandom(10));
      periodsPerAnalysis = 8'($urandom);
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      maxHold <= 1'b1;
      pub(32'h1f4, K_OTHER, 32'h1f4, 32'h1f4);
      pub(32'h12c, K_OTHER, 32'h12c, 32'h1f4);
      pub(32'h384, K_OTHER, 32'h384, 32'h384);
      maxHold <= 1'b0;
      pub(32'hab0e0, K_OTHER, 32'hab0e0, 32'hab0e0);
      $display("test max hold and count done");
      {vtRatio, ctRatio, powerCoef, sensorRatio} <= 64'h0200_0300_0180_0004;
      for (int p = 0; p < 2; p++)
      begin
         xfmrSel <= p == 0;
         sensorSel <= p == 1;
         for (int k = 0; k < 4; k++)
         begin
            d = 32'h4 * ($urandom % 1600 + 1);
            v = p ? d / dv[k] : d * xf[k];
            pub(d, 3'(k), v, v);
         end
      end
      $display("test scaling done");
      sensorSel <= 1'b0;
      avgMode <= AV_EXP;
      for (int s = 0; s < 6; s++)
      begin
         expSel <= 3'(s);
         d = 32'($urandom % 1000);
         r = 32'($urandom % 100);
         pub(d, K_OTHER, d, d);
         pub(d + (32'h2 << s) * r, K_OTHER, d + r, d + r);
      end
      $display("test exponential done");
      avgMode <= AV_MOV;
      for (int n = 0; n < 10; n++)
      begin
         d = 32'($urandom % 5000);
         win.push_back(d);
         if (win.size() > 8) void'(win.pop_front());
         v = 32'(win.sum() / win.size());
         pub(d, K_OTHER, v, v);
      end
      $display("test moving done");
      for (int n = 0; n < 8; n++)
      begin
         rangeRating <= n[0];
         elemScale <= 24'($urandom);
         repeat (2) @(posedge clk);
         m = 4'h0;
         for (int g = 0; g < 6; g++)
            if (n[0] && elemScale[4*g +: 4] > m) m = elemScale[4*g +: 4];
         check(sumScale, m);
      end
      $display("test sum scale done");
      zcValid <= 1'b1;
      measRange <= 32'h3e8;
      for (int n = 0; n < 3; n++)
      begin
         crest6 <= n == 1;
         zcCount = 0;
         for (int h = 0; h < 8; h++)
         begin
            zcSample <= h[0] ? -32'(amp[n]) : 32'(amp[n]);
            repeat (100) @(posedge clk);
         end
         if (n < 2)
            check(zcCount, 0);
         else
            check(zcPeriod, 32'hc8);
      end
      $display("test zero crossing done");
      finalReport;
   end
endmodule
